// ### dpr_regs.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - input divider is 30 bits over four bytes, low first; ratio is value plus one.
// - feedback integer divider is 20 bits over three bytes; ratio is value plus one.
// - fraction second term is byte plus two bits; first term nibble plus six bits.
// - phase-lock threshold is 16 bits, unit chosen by the profile's scale bit.
// - scale bit, top of priority byte: clear means picoseconds, set means nanoseconds.
// - frequency-lock threshold is 24 bits over three bytes, always in picoseconds.
// - both lock detectors have their own 8-bit fill and drain rates.
// - 3-bit selection priority ranks this reference among the others.
// - active reference uses promoted priority; software keeps it at or below selection.
// - nominal reference period is 40 bits in femtoseconds, five bytes low first.
// - narrow and wide tolerances are 20 bits; third byte upper nibble unused.
// - validation timer is 16 bits in milliseconds, low byte first.
// - redetect timer is 16 bits in milliseconds, in the next two bytes.
// - each loop filter coefficient is a fraction times two to an exponent.
// - linear parts 16, 17, 17, 15 bits; exponents 6, 3, 4, 5, 5, 5 bits.
// - coefficient fields straddle bytes, e.g. sixth exponent split over two bytes.
module dpr_regs
  import dpr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_active,
  output dpr_cfg_t cfg,
  output dpr_derived_t derived,
  output logic [7:0] cfg_status
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and bus decode

  logic [7:0] mem_q [NBYTES];
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  dpr_cfg_t cfg_q;
  dpr_cfg_t cfg_d;
  dpr_derived_t der_q;
  logic [7:0] stat_q;

  logic [10:0] idx;
  logic hit_mem;
  logic hit_stat;
  logic mapped;
  logic setup;
  logic fire;
  logic [5:0] slot;

  // byte slot of a printed offset
  function automatic logic [5:0] ix(input int unsigned off);
    int unsigned d;
    d = off - BASE_IDX;
    return d[5:0];
  endfunction

  assign idx = paddr[12:2];
  assign slot = 6'(idx - 11'(BASE_IDX));
  assign hit_mem = (paddr[1:0] == 2'h0) && (idx >= 11'(BASE_IDX))
                   && (idx < 11'(BASE_IDX + NBYTES));
  assign hit_stat = (paddr[1:0] == 2'h0) && (idx == 11'(STAT_IDX));
  assign mapped = hit_mem || hit_stat;
  assign setup = psel && !penable;
  // completion edge: access phase with our ready high
  assign fire = psel && penable && pready_q;

  // one wait state per access keeps read data a clean flop output
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  // error on unmapped, misaligned or status-write access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= psel && penable && !pready_q && (!mapped || (pwrite && hit_stat));
    end
  end

  // read data captured in setup, held through access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      if (!pwrite && hit_mem) begin
        prdata_q <= {24'h000000, mem_q[slot]};
      end else if (!pwrite && hit_stat) begin
        prdata_q <= {24'h000000, stat_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // byte store; unused bits masked so they read back zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NBYTES; i++) begin
        mem_q[i] <= BYTE_RST;
      end
    end else if (fire && pwrite && hit_mem && pstrb[0]) begin
      mem_q[slot] <= pwdata[7:0] & WMASK[slot];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field assembly from bytes

  always_comb begin
    cfg_d = '0;
    cfg_d.r_div = {mem_q[ix(OFF_RDIV+3)][5:0], mem_q[ix(OFF_RDIV+2)],
                   mem_q[ix(OFF_RDIV+1)], mem_q[ix(OFF_RDIV)]};
    cfg_d.s_div = {mem_q[ix(OFF_SDIV+2)][3:0], mem_q[ix(OFF_SDIV+1)],
                   mem_q[ix(OFF_SDIV)]};
    cfg_d.frac_v = {mem_q[ix(OFF_FRAC+1)][1:0], mem_q[ix(OFF_FRAC)]};
    cfg_d.frac_u = {mem_q[ix(OFF_FRAC+2)][5:0], mem_q[ix(OFF_FRAC+1)][7:4]};
    cfg_d.pl_thr = {mem_q[ix(OFF_PLTHR+1)], mem_q[ix(OFF_PLTHR)]};
    cfg_d.pl_fill = mem_q[ix(OFF_PLFILL)];
    cfg_d.pl_drain = mem_q[ix(OFF_PLDRAIN)];
    cfg_d.fl_thr = {mem_q[ix(OFF_FLTHR+2)], mem_q[ix(OFF_FLTHR+1)],
                    mem_q[ix(OFF_FLTHR)]};
    cfg_d.fl_fill = mem_q[ix(OFF_FLFILL)];
    cfg_d.fl_drain = mem_q[ix(OFF_FLDRAIN)];
    cfg_d.pl_scale_ns = mem_q[ix(OFF_PRIO)][POS_SCALE];
    cfg_d.prom_pri = mem_q[ix(OFF_PRIO)][POS_PROM+:3];
    cfg_d.sel_pri = mem_q[ix(OFF_PRIO)][POS_SEL+:3];
    cfg_d.period_fs = {mem_q[ix(OFF_PERIOD+4)], mem_q[ix(OFF_PERIOD+3)],
                       mem_q[ix(OFF_PERIOD+2)], mem_q[ix(OFF_PERIOD+1)],
                       mem_q[ix(OFF_PERIOD)]};
    cfg_d.tol_narrow = {mem_q[ix(OFF_TOLN+2)][3:0], mem_q[ix(OFF_TOLN+1)],
                        mem_q[ix(OFF_TOLN)]};
    cfg_d.tol_wide = {mem_q[ix(OFF_TOLW+2)][3:0], mem_q[ix(OFF_TOLW+1)],
                      mem_q[ix(OFF_TOLW)]};
    cfg_d.valid_ms = {mem_q[ix(OFF_VALID+1)], mem_q[ix(OFF_VALID)]};
    cfg_d.redet_ms = {mem_q[ix(OFF_REDET+1)], mem_q[ix(OFF_REDET)]};
    // coefficients: fraction times two to the exponent
    cfg_d.a0_lin = {mem_q[ix(OFF_COEF+1)], mem_q[ix(OFF_COEF)]};
    cfg_d.a1_exp = mem_q[ix(OFF_COEF+2)][5:0];
    cfg_d.a2_exp = {mem_q[ix(OFF_COEF+3)][0], mem_q[ix(OFF_COEF+2)][7:6]};
    cfg_d.b0_lin = {mem_q[ix(OFF_COEF+5)][1:0], mem_q[ix(OFF_COEF+4)],
                    mem_q[ix(OFF_COEF+3)][7:1]};
    cfg_d.b1_exp = mem_q[ix(OFF_COEF+5)][6:2];
    cfg_d.g0_lin = {mem_q[ix(OFF_COEF+8)][0], mem_q[ix(OFF_COEF+7)],
                    mem_q[ix(OFF_COEF+6)]};
    cfg_d.g1_exp = mem_q[ix(OFF_COEF+8)][5:1];
    cfg_d.d0_lin = {mem_q[ix(OFF_COEF+10)][6:0], mem_q[ix(OFF_COEF+9)]};
    cfg_d.d1_exp = {mem_q[ix(OFF_COEF+11)][3:0], mem_q[ix(OFF_COEF+10)][7]};
    cfg_d.a3_exp = mem_q[ix(OFF_COEF+11)][7:4];
  end

  // registered so the core sees glitch-free fields
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // values the core consumes directly

  // reset values match a zeroed profile: ratios of one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      der_q.r_ratio <= 31'h0000_0001;
      der_q.s_ratio <= 21'h00_0001;
      der_q.eff_pri <= 3'h0;
      der_q.pl_thr_ps <= 26'h000_0000;
    end else begin
      der_q.r_ratio <= {1'b0, cfg_q.r_div} + 31'h0000_0001;
      der_q.s_ratio <= {1'b0, cfg_q.s_div} + 21'h00_0001;
      der_q.eff_pri <= ref_active ? cfg_q.prom_pri : cfg_q.sel_pri;
      // nanosecond scale widened to picoseconds here
      der_q.pl_thr_ps <= cfg_q.pl_scale_ns ? 26'(cfg_q.pl_thr) * 26'(NS_TO_PS)
                                           : {10'h000, cfg_q.pl_thr};
    end
  end

  // software mistakes are only flagged, never corrected
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= 8'h00;
      stat_q[ST_SLOW] <= cfg_q.s_div < SDIV_MIN;
      stat_q[ST_PRIO] <= cfg_q.prom_pri > cfg_q.sel_pri;
      stat_q[ST_PAD] <= |{mem_q[ix(OFF_PAD+1)], mem_q[ix(OFF_PAD)]};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cfg = cfg_q;
  assign derived = der_q;
  assign cfg_status = stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic [5:0] wslot_h;
  logic [7:0] wval_h;
  logic wfire_h;
  // last completed write, for the readback check
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wfire_h <= 1'b0;
      wslot_h <= 6'h00;
      wval_h <= 8'h00;
    end else begin
      wfire_h <= fire && pwrite && hit_mem && pstrb[0];
      wslot_h <= slot;
      wval_h <= pwdata[7:0] & WMASK[slot];
    end
  end

  property p_readback;
    wfire_h |-> mem_q[wslot_h] == wval_h;
  endproperty
  a_readback: assert property (p_readback) else $error("byte store lost a write");

  property p_rratio;
    ##2 1 |-> der_q.r_ratio == {1'b0, $past(cfg_d.r_div, 2)} + 31'h0000_0001;
  endproperty
  a_rratio: assert property (p_rratio) else $error("input ratio not value plus one");

  property p_sratio;
    ##2 1 |-> der_q.s_ratio == {1'b0, $past(cfg_d.s_div, 2)} + 21'h00_0001;
  endproperty
  a_sratio: assert property (p_sratio) else $error("feedback ratio wrong");

  property p_scale;
    ##1 (cfg_q.pl_scale_ns == 1'b0) |=> der_q.pl_thr_ps == {10'h000, $past(cfg_q.pl_thr)};
  endproperty
  a_scale: assert property (p_scale) else $error("ps threshold altered");

  property p_frac;
    cfg_q.frac_u == {$past(mem_q[ix(OFF_FRAC+2)][5:0]), $past(mem_q[ix(OFF_FRAC+1)][7:4])};
  endproperty
  a_frac: assert property (p_frac) else $error("fraction term misassembled");

  property p_effpri;
    ##1 ref_active |=> der_q.eff_pri == $past(cfg_q.prom_pri);
  endproperty
  a_effpri: assert property (p_effpri) else $error("active priority not promoted");

  property p_slow;
    ##1 (cfg_q.s_div < SDIV_MIN) |=> stat_q[ST_SLOW];
  endproperty
  a_slow: assert property (p_slow) else $error("low divider not flagged");

  property p_tolnib;
    mem_q[ix(OFF_TOLN+2)][7:4] == 4'h0 && mem_q[ix(OFF_TOLW+2)][7:4] == 4'h0;
  endproperty
  a_tolnib: assert property (p_tolnib) else $error("unused nibble set");

  property p_ready;
    psel && penable && !pready_q |=> pready_q ##1 !pready_q;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle");

  property p_ns;
    ##1 cfg_q.pl_scale_ns |=> der_q.pl_thr_ps == 26'($past(cfg_q.pl_thr)) * 26'(NS_TO_PS);
  endproperty
  a_ns: assert property (p_ns) else $error("ns threshold not scaled to ps");

  property p_selpri;
    ##1 !ref_active |=> der_q.eff_pri == $past(cfg_q.sel_pri);
  endproperty
  a_selpri: assert property (p_selpri) else $error("idle priority not selection");

  property p_prioflag;
    ##1 (cfg_q.prom_pri > cfg_q.sel_pri) |=> stat_q[ST_PRIO];
  endproperty
  a_prioflag: assert property (p_prioflag) else $error("bad promotion not flagged");

  property p_priook;
    ##1 (cfg_q.prom_pri <= cfg_q.sel_pri) |=> !stat_q[ST_PRIO];
  endproperty
  a_priook: assert property (p_priook) else $error("good promotion flagged");

  property p_fastok;
    ##1 (cfg_q.s_div >= SDIV_MIN) |=> !stat_q[ST_SLOW];
  endproperty
  a_fastok: assert property (p_fastok) else $error("legal divider flagged");

  property p_padflag;
    (mem_q[ix(OFF_PAD)] != 8'h00 || mem_q[ix(OFF_PAD+1)] != 8'h00) |=> stat_q[ST_PAD];
  endproperty
  a_padflag: assert property (p_padflag) else $error("nonzero pad not flagged");

  property p_stathi;
    stat_q[7:3] == 5'h00;
  endproperty
  a_stathi: assert property (p_stathi) else $error("unused status bits set");

  property p_rdhi;
    prdata_q[31:8] == 24'h000000;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read lanes not zero");

  property p_errready;
    pslverr_q |-> pready_q;
  endproperty
  a_errready: assert property (p_errready) else $error("error without ready");

  property p_sdivpad;
    mem_q[ix(OFF_SDIV+3)] == 8'h00;
  endproperty
  a_sdivpad: assert property (p_sdivpad) else $error("unused divider byte set");

  property p_prio6;
    mem_q[ix(OFF_PRIO)][6] == 1'b0;
  endproperty
  a_prio6: assert property (p_prio6) else $error("unused priority bit set");

  property p_flthr;
    cfg_q.fl_thr == {$past(mem_q[ix(OFF_FLTHR+2)]), $past(mem_q[ix(OFF_FLTHR+1)]),
                     $past(mem_q[ix(OFF_FLTHR)])};
  endproperty
  a_flthr: assert property (p_flthr) else $error("lock threshold misassembled");

  property p_period;
    cfg_q.period_fs == {$past(mem_q[ix(OFF_PERIOD+4)]), $past(mem_q[ix(OFF_PERIOD+3)]),
                        $past(mem_q[ix(OFF_PERIOD+2)]), $past(mem_q[ix(OFF_PERIOD+1)]),
                        $past(mem_q[ix(OFF_PERIOD)])};
  endproperty
  a_period: assert property (p_period) else $error("period misassembled");

  property p_d1exp;
    cfg_q.d1_exp == {$past(mem_q[ix(OFF_COEF+11)][3:0]), $past(mem_q[ix(OFF_COEF+10)][7])};
  endproperty
  a_d1exp: assert property (p_d1exp) else $error("split exponent misassembled");

  property p_valid;
    cfg_q.valid_ms == {$past(mem_q[ix(OFF_VALID+1)]), $past(mem_q[ix(OFF_VALID)])};
  endproperty
  a_valid: assert property (p_valid) else $error("validation timer misassembled");

  property p_redet;
    cfg_q.redet_ms == {$past(mem_q[ix(OFF_REDET+1)]), $past(mem_q[ix(OFF_REDET)])};
  endproperty
  a_redet: assert property (p_redet) else $error("redetect timer misassembled");

  c_active: cover property (ref_active && cfg_q.prom_pri < cfg_q.sel_pri);
  c_write: cover property (fire && pwrite && hit_mem);
  c_read: cover property (fire && !pwrite && hit_mem);
  c_err: cover property (pslverr_q && pready_q);
  c_ns: cover property (cfg_q.pl_scale_ns && cfg_q.pl_thr != 16'h0000);

endmodule
`default_nettype wire

// ### dpr_pkg.sv
package dpr_pkg;

  // byte registers sit at word index = printed offset, byte address = 4 * index
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned BASE_IDX = 'h69e;
  localparam int unsigned NBYTES = 50;
  localparam int unsigned STAT_IDX = 'h6f0;

  // printed offsets of the first byte of each field group
  localparam int unsigned OFF_RDIV = 'h69e;
  localparam int unsigned OFF_SDIV = 'h6a2;
  localparam int unsigned OFF_FRAC = 'h6a6;
  localparam int unsigned OFF_PLTHR = 'h6a9;
  localparam int unsigned OFF_PLFILL = 'h6ab;
  localparam int unsigned OFF_PLDRAIN = 'h6ac;
  localparam int unsigned OFF_FLTHR = 'h6ad;
  localparam int unsigned OFF_FLFILL = 'h6b0;
  localparam int unsigned OFF_FLDRAIN = 'h6b1;
  localparam int unsigned OFF_PRIO = 'h6b2;
  localparam int unsigned OFF_PERIOD = 'h6b3;
  localparam int unsigned OFF_PAD = 'h6b8;
  localparam int unsigned OFF_TOLN = 'h6ba;
  localparam int unsigned OFF_TOLW = 'h6bd;
  localparam int unsigned OFF_VALID = 'h6c0;
  localparam int unsigned OFF_REDET = 'h6c2;
  localparam int unsigned OFF_COEF = 'h6c4;

  // field positions inside the priority byte
  localparam int unsigned POS_SCALE = 7;
  localparam int unsigned POS_PROM = 3;
  localparam int unsigned POS_SEL = 0;

  // status byte bits
  localparam int unsigned ST_SLOW = 0;
  localparam int unsigned ST_PRIO = 1;
  localparam int unsigned ST_PAD = 2;

  localparam logic [19:0] SDIV_MIN = 20'h00007;
  localparam logic [9:0] NS_TO_PS = 10'h3e8;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // writable bits per byte; the rest always read zero
  localparam logic [7:0] WMASK [NBYTES] = '{
    8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h0f, 8'h00, 8'hff, 8'hf3,
    8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hbf, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff
  };

  typedef struct packed {
    logic [29:0] r_div;
    logic [19:0] s_div;
    logic [9:0] frac_v;
    logic [9:0] frac_u;
    logic [15:0] pl_thr;
    logic [7:0] pl_fill;
    logic [7:0] pl_drain;
    logic [23:0] fl_thr;
    logic [7:0] fl_fill;
    logic [7:0] fl_drain;
    logic pl_scale_ns;
    logic [2:0] prom_pri;
    logic [2:0] sel_pri;
    logic [39:0] period_fs;
    logic [19:0] tol_narrow;
    logic [19:0] tol_wide;
    logic [15:0] valid_ms;
    logic [15:0] redet_ms;
    logic [15:0] a0_lin;
    logic [5:0] a1_exp;
    logic [2:0] a2_exp;
    logic [3:0] a3_exp;
    logic [16:0] b0_lin;
    logic [4:0] b1_exp;
    logic [16:0] g0_lin;
    logic [4:0] g1_exp;
    logic [14:0] d0_lin;
    logic [4:0] d1_exp;
  } dpr_cfg_t;

  typedef struct packed {
    logic [30:0] r_ratio;
    logic [20:0] s_ratio;
    logic [2:0] eff_pri;
    logic [25:0] pl_thr_ps;
  } dpr_derived_t;

endpackage

// ### dpll_reference_profile_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dpll_reference_profile_regs_bench;
  import dpr_pkg::*;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, ref_active, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0] pstrb;
  dpr_cfg_t cfg;
  dpr_derived_t derived;
  logic [7:0] cfg_status;
  logic [7:0] sh [NBYTES];
  int miscompares = 0;
  int compares = 0;
  int seed = 32'ha3b5d772;

  dpr_regs DUT (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_active(ref_active), .cfg(cfg), .derived(derived),
    .cfg_status(cfg_status));

  ////////////////////////////////////////////////////////////////////////////////
  // free-running 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic complete_run;
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [511:0] seen, input logic [511:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input int idx, input logic [1:0] lsb,
                     input logic [7:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ADDR_W'(idx * 4) | ADDR_W'(lsb);
    pwdata <= {24'($random(seed)), wd}; // upper lanes are junk on purpose
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    chk("wait_states", n, 2);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // shadow keeps only the writable bits, unused ones read zero
  task automatic wr(input int idx, input logic [7:0] d);
    apb(1'b1, idx, 2'b00, d, 4'hf);
    sh[idx - BASE_IDX] = d & WMASK[idx - BASE_IDX];
    chk("wr_err", err, 1'b0);
  endtask

  task automatic rdchk(input int idx);
    apb(1'b0, idx, 2'b00, 8'h00, 4'h0);
    chk("rdata", rd, {24'h0, sh[idx - BASE_IDX]});
    chk("rd_err", err, 1'b0);
  endtask

  // refused access: error flagged, reads give zero
  task automatic bad(input logic w, input int idx, input logic [1:0] lsb);
    apb(w, idx, lsb, 8'h5a, 4'hf);
    chk("refuse_err", err, 1'b1);
    if (!w) chk("refuse_rd", rd, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // expected decode of the shadow bytes, low byte at lowest index
  function automatic dpr_cfg_t exp_cfg();
    dpr_cfg_t c;
    c.r_div = {sh[3][5:0], sh[2], sh[1], sh[0]};
    c.s_div = {sh[6][3:0], sh[5], sh[4]};
    c.frac_v = {sh[9][1:0], sh[8]};
    c.frac_u = {sh[10][5:0], sh[9][7:4]};
    c.pl_thr = {sh[12], sh[11]};
    c.pl_fill = sh[13];
    c.pl_drain = sh[14];
    c.fl_thr = {sh[17], sh[16], sh[15]};
    c.fl_fill = sh[18];
    c.fl_drain = sh[19];
    c.pl_scale_ns = sh[20][7];
    c.prom_pri = sh[20][5:3];
    c.sel_pri = sh[20][2:0];
    c.period_fs = {sh[25], sh[24], sh[23], sh[22], sh[21]};
    c.tol_narrow = {sh[30][3:0], sh[29], sh[28]};
    c.tol_wide = {sh[33][3:0], sh[32], sh[31]};
    c.valid_ms = {sh[35], sh[34]};
    c.redet_ms = {sh[37], sh[36]};
    c.a0_lin = {sh[39], sh[38]};
    c.a1_exp = sh[40][5:0];
    c.a2_exp = {sh[41][0], sh[40][7:6]};
    c.b0_lin = {sh[43][1:0], sh[42], sh[41][7:1]};
    c.b1_exp = sh[43][6:2];
    c.g0_lin = {sh[46][0], sh[45], sh[44]};
    c.g1_exp = sh[46][5:1];
    c.d0_lin = {sh[48][6:0], sh[47]};
    c.d1_exp = {sh[49][3:0], sh[48][7]};
    c.a3_exp = sh[49][7:4];
    return c;
  endfunction

  // decoded outputs lag the last store by up to two edges
  task automatic check_all;
    dpr_cfg_t e;
    logic [7:0] st;
    repeat (4) @(posedge mclk);
    e = exp_cfg();
    st = {5'h00, |{sh[26], sh[27]}, e.prom_pri > e.sel_pri, e.s_div < 20'd7};
    chk("r_div", cfg.r_div, e.r_div);
    chk("r_ratio", derived.r_ratio, 31'(e.r_div) + 31'd1);
    chk("s_div", cfg.s_div, e.s_div);
    chk("s_ratio", derived.s_ratio, 21'(e.s_div) + 21'd1);
    chk("frac", {cfg.frac_u, cfg.frac_v}, {e.frac_u, e.frac_v});
    chk("pl_thr", cfg.pl_thr, e.pl_thr);
    chk("pl_thr_ps", derived.pl_thr_ps,
        e.pl_scale_ns ? 26'(e.pl_thr) * 26'd1000 : 26'(e.pl_thr));
    chk("fl_thr", cfg.fl_thr, e.fl_thr);
    chk("rates", {cfg.pl_fill, cfg.pl_drain, cfg.fl_fill, cfg.fl_drain},
        {e.pl_fill, e.pl_drain, e.fl_fill, e.fl_drain});
    chk("prio", {cfg.pl_scale_ns, cfg.prom_pri, cfg.sel_pri},
        {e.pl_scale_ns, e.prom_pri, e.sel_pri});
    chk("eff_pri", derived.eff_pri, ref_active ? e.prom_pri : e.sel_pri);
    chk("period", cfg.period_fs, e.period_fs);
    chk("tol", {cfg.tol_narrow, cfg.tol_wide}, {e.tol_narrow, e.tol_wide});
    chk("valid_ms", cfg.valid_ms, e.valid_ms);
    chk("redet_ms", cfg.redet_ms, e.redet_ms);
    chk("coef", cfg[92:0], e[92:0]);
    chk("status", cfg_status, st);
    apb(1'b0, STAT_IDX, 2'b00, 8'h00, 4'h0);
    chk("status_rd", rd, {24'h0, st});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: far above the few thousand cycles the sequence needs
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    complete_run();
  end

  // main sequence, run twice so a mid-run reset is covered
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    ref_active = 1'b0;
    for (int p = 0; p < 2; p++) begin
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < NBYTES; i++) sh[i] = 8'h00;
      for (int i = 0; i < NBYTES; i++) rdchk(BASE_IDX + i);
      check_all();
      // random fill; pad bytes zero except in the last round
      for (int r = 0; r < 5; r++) begin
        for (int i = 0; i < NBYTES; i++) begin
          v = $random(seed);
          if ((i == 26 || i == 27) && r != 4) v = 32'h0;
          wr(BASE_IDX + i, v[7:0]);
        end
        ref_active <= v[8];
        for (int i = 0; i < NBYTES; i++) rdchk(BASE_IDX + i);
        check_all();
      end
    end
    // boundaries: divider 5..8 around seven, promoted 3..6 against selection 4
    for (int k = 0; k < 4; k++) begin
      wr(OFF_SDIV, 8'(5 + k));
      wr(OFF_SDIV + 1, 8'h00);
      wr(OFF_SDIV + 2, 8'h00);
      wr(OFF_PRIO, {k[0], 1'b1, 3'(3 + k), 3'd4});
      wr(OFF_PLTHR, 8'hff);
      wr(OFF_PLTHR + 1, 8'hff);
      ref_active <= k[1];
      check_all();
    end
    // refusals must leave every byte untouched
    bad(1'b0, BASE_IDX - 1, 2'b00);
    bad(1'b0, BASE_IDX + NBYTES, 2'b00);
    bad(1'b1, BASE_IDX + NBYTES, 2'b00);
    bad(1'b0, OFF_PERIOD, 2'b01);
    bad(1'b1, OFF_PERIOD, 2'b10);
    bad(1'b1, STAT_IDX, 2'b00);
    apb(1'b1, OFF_PLFILL, 2'b00, ~sh[OFF_PLFILL - BASE_IDX], 4'h0);
    chk("nostrobe_err", err, 1'b0);
    for (int i = 0; i < NBYTES; i++) rdchk(BASE_IDX + i);
    check_all();
    complete_run();
  end
endmodule
`default_nettype wire
